// file: core/bsr_consts.svh
// Constants for the burst setup and latency block.
`ifndef BSR_CONSTS_SVH
`define BSR_CONSTS_SVH
`define BSR_RESET_VALUE 22'h009D1F
`define BSR_BL_LSB 0
`define BSR_WRAP_BIT 3
`define BSR_DRV_LSB 4
`define BSR_WCFG_BIT 8
`define BSR_WPOL_BIT 10
`define BSR_LAT_LSB 11
`define BSR_FIXED_BIT 14
`define BSR_ROW_LAST 8'hFF
`define BSR_BL_CONT 3'h7
`define BSR_DRV_FULL 2'h0
`define BSR_DRV_HALF 2'h1
`define BSR_DRV_QUARTER 2'h2
`endif

// file: core/bsr_pkg.sv
// Types for the burst setup and latency block.
package bsr_pkg;
    typedef struct packed {
        logic [1:0] drive;
        logic stall_early;
        logic stall_high;
        logic fixed_lat;
        logic [2:0] lat_code;
        logic linear;
        logic [2:0] burst_len;
    } bsr_cfg_t;
    typedef struct packed {
        logic [15:0] data;
        logic [7:0] col;
    } bsr_word_t;
    typedef enum logic [2:0] {
        BSR_IDLE = 3'h1,
        BSR_LAT = 3'h2,
        BSR_XFER = 3'h4
    } bsr_state_t;
endpackage

// file: core/bsr_burst.sv
// Burst setup register, latency counter, stall flag and column sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "bsr_consts.svh"

// Summary of operation
// - No-wrap steps linearly, stops at column 255.
// - Drive bits choose full, half, quarter drive.
// - Stall timing 0: data starts on flag edge.
// - Stall timing 1: flag leads data one clock.
// - Polarity bit sets asserted flag level.
// - Latency code sets clocks to first data.
// - Fixed mode reads always use worst-case latency.
// - Variable latency 3/4/5/6/7, collision 4/6/8/10/12.
// - Data transfers the cycle after latency.
// - Writes use code, never refresh lengthened.
// - Wrap bit: 0 wraps, 1 linear.
// - Length codes 4/8/16/32 or continuous.
module bsr_burst (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_cfg_we,
    input wire logic [21:0] i_cfg_data,
    output logic [21:0] o_cfg_data,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [7:0] i_start_col,
    input wire logic i_refresh_hit,
    input wire logic i_stop,
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rd_data,
    output logic o_rd_ready,
    input wire logic i_out_ready,
    output logic o_out_valid,
    output bsr_pkg::bsr_word_t o_out,
    output logic [7:0] o_col,
    output logic o_busy,
    output logic o_stall,
    output logic [1:0] o_drive
);
    logic [21:0] setup;
    bsr_pkg::bsr_cfg_t cfg;
    bsr_pkg::bsr_state_t state;
    logic [3:0] lat_cnt;
    logic [3:0] lat_target;
    logic [7:0] col;
    logic [7:0] grp_mask;
    logic [5:0] beats;
    logic is_write;
    logic stall_raw;
    logic stall_late;
    logic data_ok;
    bsr_pkg::bsr_word_t buf_q [2];
    logic [1:0] buf_cnt;
    logic buf_wp;
    logic buf_rp;
    logic push;
    logic pop;

    // Burst length in beats; zero means continuous to the row end.
    function automatic logic [5:0] burst_beats(input logic [2:0] code);
        case (code)
            3'h1: burst_beats = 6'h04;
            3'h2: burst_beats = 6'h08;
            3'h3: burst_beats = 6'h10;
            3'h4: burst_beats = 6'h20;
            default: burst_beats = 6'h00;
        endcase
    endfunction

    // Latency in clocks for a code and a refresh collision.
    function automatic logic [3:0] lat_clocks(input logic [2:0] code, input logic hit);
        case (code)
            3'h2: lat_clocks = hit ? 4'h4 : 4'h3;
            3'h3: lat_clocks = hit ? 4'h6 : 4'h4;
            3'h4: lat_clocks = hit ? 4'h8 : 4'h5;
            3'h5: lat_clocks = hit ? 4'hA : 4'h6;
            3'h6: lat_clocks = hit ? 4'hC : 4'h7;
            default: lat_clocks = hit ? 4'h6 : 4'h4;
        endcase
    endfunction

    // Register unpacking into the configuration fields.
    assign cfg.burst_len = setup[`BSR_BL_LSB +: 3];
    assign cfg.linear = setup[`BSR_WRAP_BIT];
    assign cfg.drive = setup[`BSR_DRV_LSB +: 2];
    assign cfg.stall_early = setup[`BSR_WCFG_BIT];
    assign cfg.stall_high = setup[`BSR_WPOL_BIT];
    assign cfg.lat_code = setup[`BSR_LAT_LSB +: 3];
    assign cfg.fixed_lat = setup[`BSR_FIXED_BIT];
    assign o_cfg_data = setup;

    // Setup register; writes are refused while a burst runs to keep timing stable.
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            setup <= `BSR_RESET_VALUE;
        else if (i_cfg_we && state == bsr_pkg::BSR_IDLE)
            setup <= i_cfg_data;
    end

    // drive code, reserved code falls back to half.
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_drive <= `BSR_DRV_HALF;
        else if (cfg.drive == 2'h3)
            o_drive <= `BSR_DRV_HALF;
        else
            o_drive <= cfg.drive;
    end

    // latency target chosen at burst start.
    // fixed mode reads take the worst-case figure.
    // variable read lengthens only on collision.
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state <= bsr_pkg::BSR_IDLE;
            lat_cnt <= 4'h0;
            lat_target <= 4'h0;
            is_write <= 1'b0;
        end
        else
        begin
            case (state)
                bsr_pkg::BSR_IDLE:
                    if (i_start)
                    begin
                        state <= bsr_pkg::BSR_LAT;
                        lat_cnt <= 4'h1;
                        is_write <= i_write;
                        lat_target <= lat_clocks(cfg.lat_code,
                            !i_write && (cfg.fixed_lat || i_refresh_hit));
                    end
                bsr_pkg::BSR_LAT:
                    // data transfers on the cycle after the count.
                    if (lat_cnt == lat_target)
                        state <= bsr_pkg::BSR_XFER;
                    else
                        lat_cnt <= lat_cnt + 4'h1;
                bsr_pkg::BSR_XFER:
                    if (i_stop || (data_ok && last_beat()))
                        state <= bsr_pkg::BSR_IDLE;
                default:
                    state <= bsr_pkg::BSR_IDLE;
            endcase
        end
    end

    // Last beat of the burst or of the row.
    function automatic logic last_beat();
        last_beat = (beats == 6'h01) || (cfg.linear && col == `BSR_ROW_LAST)
            || (beats == 6'h00 && col == `BSR_ROW_LAST);
    endfunction

    // A write beat moves every transfer clock; a read beat moves when data is there and the buffer can take it.
    assign data_ok = state == bsr_pkg::BSR_XFER && (is_write || (i_rd_valid && buf_cnt != 2'h2));
    assign push = data_ok && !is_write;
    assign pop = o_out_valid && i_out_ready;
    assign o_rd_ready = state == bsr_pkg::BSR_XFER && !is_write && buf_cnt != 2'h2;

    // Column bits that move inside a wrapping group; widened once so no slice of a call is needed.
    assign grp_mask = {2'h0, burst_beats(cfg.burst_len)} - 8'h01;

    // no-wrap runs linearly and halts at column 255.
    // wrap keeps the column inside its group.
    // group size taken from the length code.
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            col <= 8'h00;
            beats <= 6'h00;
        end
        else if (state == bsr_pkg::BSR_IDLE && i_start)
        begin
            col <= i_start_col;
            beats <= burst_beats(cfg.burst_len);
        end
        else if (data_ok)
        begin
            if (beats != 6'h00)
                beats <= beats - 6'h01;
            if (!cfg.linear && beats != 6'h00)
                col <= (col & ~grp_mask) | ((col + 8'h01) & grp_mask);
            else if (col != `BSR_ROW_LAST)
                col <= col + 8'h01;
        end
    end
    assign o_col = col;
    assign o_busy = state != bsr_pkg::BSR_IDLE;

    // Two-entry buffer so that a stalled receiver loses no read word.
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            buf_cnt <= 2'h0;
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
        end
        else
        begin
            if (push)
                buf_wp <= ~buf_wp;
            if (pop)
                buf_rp <= ~buf_rp;
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge i_mclk)
    begin
        if (push)
            buf_q[buf_wp] <= '{data: i_rd_data, col: col};
    end
    assign o_out_valid = buf_cnt != 2'h0;
    assign o_out = buf_q[buf_rp];

    // late mode flag changes in the same clock as the data.
    // early mode flag leads the data one clock.
    assign stall_raw = !(state == bsr_pkg::BSR_XFER || (state == bsr_pkg::BSR_LAT
        && lat_cnt == lat_target));
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            stall_late <= 1'b1;
        else
            stall_late <= stall_raw;
    end

    // polarity bit sets the asserted level.
    assign o_stall = (cfg.stall_early ? stall_raw : stall_late) ~^ cfg.stall_high;

    // Checks on the timing of the burst.
    sequence s_start_var;
        state == bsr_pkg::BSR_IDLE && i_start && !i_write && !cfg.fixed_lat && !i_refresh_hit
            && cfg.lat_code == 3'h3;
    endsequence
    a_var_latency: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        s_start_var |=> (state == bsr_pkg::BSR_LAT)[*4] ##1 state == bsr_pkg::BSR_XFER)
        else $error("variable latency wrong");
    a_write_nohit: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        state == bsr_pkg::BSR_IDLE && i_start && i_write |=> lat_target == lat_clocks(cfg.lat_code,
        1'b0)) else $error("write latency lengthened");
    a_row_stop: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        data_ok && cfg.linear && col == `BSR_ROW_LAST |=> col == `BSR_ROW_LAST)
        else $error("column passed row end");
    a_stall_lead: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        cfg.stall_early && $fell(stall_raw) |=> state == bsr_pkg::BSR_XFER)
        else $error("early flag did not lead data");
    a_drive_code: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        cfg.drive != 2'h3 && $stable(cfg.drive) |=> o_drive == $past(cfg.drive))
        else $error("drive code not applied");
    a_fixed_worst: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        state == bsr_pkg::BSR_IDLE && i_start && !i_write && cfg.fixed_lat
        |=> lat_target == lat_clocks(cfg.lat_code, 1'b1)) else $error("fixed latency wrong");
    a_buf_full: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        buf_cnt != 2'h3 && !(buf_cnt == 2'h2 && o_rd_ready)) else $error("buffer overrun");
    a_stall_pol: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        state == bsr_pkg::BSR_IDLE ##1 state == bsr_pkg::BSR_IDLE |-> o_stall == cfg.stall_high)
        else $error("stall polarity wrong");
endmodule
`default_nettype wire

// file: dv/bsr_ctrl_model.sv
// Far-side model: array word feeder and stalling output consumer.
`timescale 1ns/10ps
`default_nettype none
// ----------
// Controller side
// ----------
module bsr_ctrl_model (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_slow,
    input wire logic i_rd_ready,
    output logic o_rd_valid,
    output logic [15:0] o_rd_data,
    output logic o_out_ready
);
    logic [3:0] tick;
    // A word stands until taken; while no word is offered the bus keeps changing.
    // pacing by flow
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tick <= 4'h0;
            o_rd_valid <= 1'h0;
            o_rd_data <= 16'h0000;
            o_out_ready <= 1'h0;
        end
        else
        begin
            tick <= tick + 4'h1;
            o_out_ready <= !(i_slow && tick[1]);
            if (!o_rd_valid || i_rd_ready)
            begin
                o_rd_valid <= !(i_slow && tick[2]);
                o_rd_data <= o_rd_data + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the burst setup and latency block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin check_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
    logic i_mclk = 0, i_nrst = 0, i_cfg_we = 0, i_start = 0, i_write = 0;
    logic i_refresh_hit = 0, i_stop = 0, i_slow = 0;
    logic [21:0] i_cfg_data = 22'h000000, o_cfg_data;
    logic [7:0] i_start_col = 8'h00, o_col;
    logic rd_valid, rd_ready, out_ready, o_out_valid, o_busy, o_stall;
    logic [15:0] rd_data;
    logic [1:0] o_drive;
    bsr_pkg::bsr_word_t o_out;
    logic [7:0] cols[$];
    logic [15:0] sent[$], dats[$];
    logic [7:0] rows[12] = '{8'h43, 8'h63, 8'h83, 8'h53, 8'h73, 8'h93, 8'h6B, 8'h97,
        8'h61, 8'h42, 8'hA2, 8'hC9};
    logic [7:0] r;
    int miscompares = 0, check_count = 0, n;
    bsr_burst u_bsr_burst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cfg_we(i_cfg_we),
        .i_cfg_data(i_cfg_data), .o_cfg_data(o_cfg_data), .i_start(i_start),
        .i_write(i_write), .i_start_col(i_start_col), .i_refresh_hit(i_refresh_hit),
        .i_stop(i_stop), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_rd_ready(rd_ready),
        .i_out_ready(out_ready), .o_out_valid(o_out_valid), .o_out(o_out), .o_col(o_col),
        .o_busy(o_busy), .o_stall(o_stall), .o_drive(o_drive));
    bsr_ctrl_model u_bsr_ctrl_model (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_slow(i_slow),
        .i_rd_ready(rd_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_out_ready(out_ready));
    // ----------
    // Clock, watchdog and helpers
    // ----------
    always #12.5 i_mclk = ~i_mclk;
    // Words handed in and popped out are logged so order and loss can be judged afterwards.
    always @(posedge i_mclk)
    begin
        if (o_out_valid && out_ready)
        begin
            cols.push_back(o_out.col);
            dats.push_back(o_out.data);
        end
        if (rd_valid && rd_ready)
            sent.push_back(rd_data);
    end
    // The whole run needs well under 4000 cycles; a hang is cut here.
    initial
    begin
        #(25 * 4000);
        miscompares++;
        close_out;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [21:0] cfg(input logic [2:0] bl, input logic wr,
        input logic [1:0] dr, input logic e, input logic h, input logic [2:0] lat,
        input logic f);
        return {7'h00, f, lat, h, 1'h0, e, 2'h0, dr, wr, bl};
    endfunction
    // Writes ignore collisions; fixed reads take the collision figure; late flag adds one.
    function automatic int lat_of(input logic [7:0] v);
        return (v[2] || !(v[4] || v[3]) ? v[7:5] + 1 : 2 * v[7:5]) + !v[1];
    endfunction
    task automatic put_cfg(input logic [21:0] v);
        @(negedge i_mclk) i_cfg_we = 1;
        i_cfg_data = v;
        @(negedge i_mclk) i_cfg_we = 0;
        `CHK("setup", v, o_cfg_data)
    endtask
    task automatic go(input logic [7:0] c, input logic w, input logic h);
        @(negedge i_mclk) i_start = 1;
        i_start_col = c;
        i_write = w;
        i_refresh_hit = h;
        @(negedge i_mclk) i_start = 0;
    endtask
    // Stop is driven to s and held until the block goes idle, then the buffer is let drain.
    task automatic end_burst(input logic s);
        @(negedge i_mclk) i_stop = s;
        repeat (80) if (o_busy === 1'h1) @(negedge i_mclk);
        i_stop = 0;
        repeat (20) if (o_out_valid === 1'h1) @(negedge i_mclk);
        `CHK("idle", 1'h0, o_busy)
    endtask
    task automatic seq(input logic [2:0] bl, input logic wr, input logic [7:0] c, input int k);
        logic [7:0] e, m;
        e = c;
        m = (8'h02 << bl) - 8'h01;
        put_cfg(cfg(bl, wr, 2'h0, 1'h1, 1'h1, 3'h3, 1'h0));
        cols.delete();
        sent.delete();
        dats.delete();
        go(c, 1'h0, 1'h0);
        repeat (400) if (cols.size() < k) @(negedge i_mclk);
        end_burst(bl == 3'h7);
        for (int j = 0; j < k; j++)
        begin
            `CHK("column", e, cols[j])
            `CHK("data", sent[j], dats[j])
            e = wr ? (e == 8'hFF ? e : e + 8'h01) : (e & ~m) | ((e + 8'h01) & m);
        end
        `CHK("beats", k, cols.size())
        $display("test sequence done");
    endtask
    // ----------
    // Tests
    // ----------
    initial
    begin
        repeat (2) @(negedge i_mclk);
        i_nrst = 1;
        `CHK("reset setup", 22'h009D1F, o_cfg_data)
        `CHK("reset drive", 2'h1, o_drive)
        `CHK("reset flag", 1'h1, o_stall)
        for (int d = 0; d < 4; d++)
        begin
            put_cfg(cfg(3'h7, 1'h1, d[1:0], 1'h1, 1'h1, 3'h3, 1'h0));
            @(negedge i_mclk);
            `CHK("drive", d == 3 ? 2'h1 : d[1:0], o_drive)
        end
        $display("test drive done");
        // Each row packs code, collision, fixed, write, flag timing and polarity.
        foreach (rows[k])
        begin
            r = rows[k];
            put_cfg(cfg(3'h7, 1'h1, 2'h1, r[1], r[0], r[7:5], r[3]));
            `CHK("idle flag", r[0], o_stall)
            go(8'h10, r[2], r[4]);
            n = 1;
            while (o_stall === r[0] && n < 40)
            begin
                @(negedge i_mclk);
                n++;
            end
            `CHK("latency", lat_of(r), n)
            `CHK("ready flag", !r[0], o_stall)
            `CHK("start column", 8'h10, o_col)
            end_burst(1'h1);
        end
        $display("test latency done");
        i_slow = 1;
        seq(3'h1, 1'h1, 8'hFC, 4);
        seq(3'h2, 1'h1, 8'hFE, 2);
        seq(3'h7, 1'h1, 8'hFB, 5);
        for (int b = 1; b < 5; b++)
            seq(b[2:0], 1'h0, 8'h0E, 2 << b);
        i_slow = 0;
        seq(3'h3, 1'h1, 8'h07, 16);
        close_out;
    end
endmodule
`default_nettype wire
